// ---- rtl/usio_cfg.svh ----
// constants for the uart system and io command handler
`ifndef USIO_CFG_SVH
`define USIO_CFG_SVH
`define USIO_CLK_HZ 32'd200000000
`define USIO_CMD_DUMMY 8'h00
`define USIO_CMD_SLEEP 8'h03
`define USIO_CMD_RESET 8'h04
`define USIO_CMD_BAUD 8'h05
`define USIO_CMD_DTYPE 8'h06
`define USIO_CMD_HTYPE 8'h07
`define USIO_CMD_SETPIN 8'h08
`define USIO_CMD_GETPIN 8'h09
`define USIO_WAKE_BYTE 8'h00
`define USIO_CFG_MAX 8'h01
`define USIO_PIN_HIZ 2'h0
`define USIO_PIN_IN 2'h1
`define USIO_PIN_LOW 2'h2
`define USIO_PIN_HIGH 2'h3
`define USIO_PIN_MODE_MAX 8'h03
`define USIO_NPIO 8
`define USIO_ST_ACK 8'h01
`define USIO_ST_NACK 8'h02
`define USIO_ST_START 8'h03
`define USIO_HDR_A 8'ha5
`define USIO_HDR_B 8'h5a
`define USIO_CRYPT_KEY 8'h3c
`define USIO_RPL_HEAD 3'd3
// fast start-up rate keeps the first exchange short; divider comes out exact
`define USIO_BAUD_RST 32'd2000000
`define USIO_DIV_RST 16'((`USIO_CLK_HZ) / (`USIO_BAUD_RST))
`define USIO_DIV_MIN 32'd16
`define USIO_DIV_MAX 32'd65535
`define USIO_INIT_US 32'd10
`define USIO_INIT_CYC (`USIO_INIT_US * (`USIO_CLK_HZ / 32'd1000000))
`define USIO_HOLD_MS 32'd50
`define USIO_HOLD_CYC (`USIO_HOLD_MS * (`USIO_CLK_HZ / 32'd1000))
`endif

// ---- rtl/usio_pkg.sv ----
// types and shared arithmetic for the command handler
package usio_pkg;
`include "usio_cfg.svh"
  typedef enum logic [2:0] {DS_INIT, DS_CMD, DS_ARG, DS_EXEC, DS_SEND, DS_SLEEP} usio_dstate_t;
  typedef enum logic [2:0] {PO_NONE, PO_SLEEP, PO_RESET, PO_BAUD, PO_DTYPE, PO_HTYPE} usio_post_t;
  typedef enum logic [1:0] {HS_IDLE, HS_SEND, HS_RX, HS_POST} usio_hstate_t;

  // argument bytes that follow each command code
  function automatic logic [2:0] usio_arg_count(input logic [7:0] code);
    logic [2:0] n;
    n = 3'd0;
    if (code == `USIO_CMD_BAUD) n = 3'd4;
    else if (code == `USIO_CMD_SETPIN) n = 3'd2;
    else if (code == `USIO_CMD_DTYPE || code == `USIO_CMD_HTYPE || code == `USIO_CMD_GETPIN)
      n = 3'd1;
    return n;
  endfunction

  // nearest divider for a requested rate, clamped to the range 16 through 65535
  function automatic logic [15:0] usio_div_of(input logic [31:0] rate);
    logic [31:0] q;
    q = (rate == 32'h0) ? `USIO_DIV_MAX : (`USIO_CLK_HZ + (rate >> 1)) / rate;
    if (q < `USIO_DIV_MIN) q = `USIO_DIV_MIN;
    if (q > `USIO_DIV_MAX) q = `USIO_DIV_MAX;
    return q[15:0];
  endfunction

  function automatic logic [31:0] usio_rate_of(input logic [15:0] div);
    return `USIO_CLK_HZ / {16'h0, div};
  endfunction
endpackage

// ---- rtl/usio_if.sv ----
// serial link between host and device
`timescale 1ns/100ps
interface usio_if;
  logic h2d;
  logic d2h;
  modport dev (input h2d, output d2h);
  modport host (output h2d, input d2h);
endinterface

// ---- rtl/usio_uart.sv ----
// 8n1 byte transmitter and receiver with a run-time divider
`timescale 1ns/100ps
module usio_uart (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // bit period in clock cycles
  input wire logic [15:0] div,
  // transmit side
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_busy,
  output logic tx_line,
  // receive side
  input wire logic rx_line,
  output logic rx_valid,
  output logic [7:0] rx_data
);
  logic [15:0] tx_cnt_reg;
  logic [3:0] tx_bit_reg;
  logic [9:0] tx_sh_reg;
  logic [15:0] rx_cnt_reg;
  logic [3:0] rx_bit_reg;
  logic rx_act_reg;
  logic rx_prev_reg;
  wire tx_tick = (tx_cnt_reg == 16'h0);
  wire rx_tick = (rx_cnt_reg == 16'h0);
  wire rx_fall = rx_prev_reg & ~rx_line;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_busy <= 1'b0;
      tx_line <= 1'b1;
      tx_cnt_reg <= 16'h0;
      tx_bit_reg <= 4'h0;
      tx_sh_reg <= 10'h3ff;
    end else if (!tx_busy) begin
      if (tx_valid) begin
        tx_busy <= 1'b1;
        tx_sh_reg <= {1'b1, tx_data, 1'b0};
        tx_cnt_reg <= 16'h0;
        tx_bit_reg <= 4'h0;
      end
    end else if (tx_tick) begin
      // busy stays up through the whole stop bit
      if (tx_bit_reg == 4'ha) begin
        tx_busy <= 1'b0;
      end else begin
        tx_line <= tx_sh_reg[0];
        tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
        tx_bit_reg <= tx_bit_reg + 4'h1;
        tx_cnt_reg <= div - 16'h1;
      end
    end else begin
      tx_cnt_reg <= tx_cnt_reg - 16'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_prev_reg <= 1'b1;
      rx_act_reg <= 1'b0;
      rx_cnt_reg <= 16'h0;
      rx_bit_reg <= 4'h0;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
    end else begin
      rx_prev_reg <= rx_line;
      rx_valid <= 1'b0;
      if (!rx_act_reg) begin
        if (rx_fall) begin
          rx_act_reg <= 1'b1;
          rx_cnt_reg <= div >> 1;
          rx_bit_reg <= 4'h0;
        end
      end else if (rx_tick) begin
        rx_cnt_reg <= div - 16'h1;
        rx_bit_reg <= rx_bit_reg + 4'h1;
        // a start bit that is high again was a glitch
        if (rx_bit_reg == 4'h0 && rx_line) rx_act_reg <= 1'b0;
        if (rx_bit_reg != 4'h0 && rx_bit_reg != 4'h9) rx_data <= {rx_line, rx_data[7:1]};
        if (rx_bit_reg == 4'h9) begin
          rx_act_reg <= 1'b0;
          rx_valid <= rx_line;
        end
      end else begin
        rx_cnt_reg <= rx_cnt_reg - 16'h1;
      end
    end
  end
endmodule // usio_uart

// ---- rtl/usio_dev.sv ----
// device end: executes system and io commands received over the link
`timescale 1ns/100ps
`include "usio_cfg.svh"
module usio_dev
  import usio_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // link
  usio_if.dev lnk,
  // general purpose pins
  input wire logic [`USIO_NPIO-1:0] gpio_in,
  output logic [`USIO_NPIO-1:0] gpio_out,
  output logic [`USIO_NPIO-1:0] gpio_oe_n,
  output logic [`USIO_NPIO-1:0] gpio_ie,
  // status
  output logic asleep,
  output logic data_enc,
  output logic hdr_b,
  output logic [31:0] baud_rate,
  output logic nv_write
);
  import usio_pkg::*;

  usio_dstate_t state_reg;
  usio_post_t post_reg;
  logic [7:0] cmd_reg;
  logic [31:0] arg_reg;
  logic [2:0] idx_reg;
  logic [2:0] len_reg;
  logic [7:0] rpl_reg [0:6];
  logic [15:0] div_reg;
  logic [15:0] div_new_reg;
  logic [31:0] baud_new_reg;
  logic [31:0] init_cnt_reg;
  logic tx_vld_reg;
  logic [7:0] tx_dat_reg;
  logic tx_busy;
  logic rx_valid;
  logic [7:0] rx_data;

  // decode of the received command
  wire [2:0] n_args = usio_arg_count(rx_data);
  wire [7:0] pin_idx = arg_reg[7:0];
  wire [7:0] pin_arg = arg_reg[15:8];
  wire [2:0] pin_sel = pin_idx[2:0];
  wire pin_ok = (pin_idx < 8'(`USIO_NPIO));
  wire mode_ok = (pin_arg <= `USIO_PIN_MODE_MAX);
  wire cfg_ok = (arg_reg[7:0] <= `USIO_CFG_MAX);
  wire [15:0] req_div = usio_div_of(arg_reg);
  wire [31:0] got_rate = usio_rate_of(req_div);
  wire pin_lvl = pin_ok & gpio_in[pin_sel];
  wire cmd_known = (cmd_reg <= `USIO_CMD_GETPIN) && (cmd_reg != 8'h01) && (cmd_reg != 8'h02);
  wire is_baud = (cmd_reg == `USIO_CMD_BAUD);
  wire is_get = (cmd_reg == `USIO_CMD_GETPIN);
  wire [2:0] rpl_np = is_baud ? 3'd4 : (is_get ? 3'd1 : 3'd0);
  wire [31:0] rpl_par = is_baud ? got_rate : {31'h0, pin_lvl};
  wire [7:0] rpl_hdr = hdr_b ? `USIO_HDR_B : `USIO_HDR_A;
  wire [7:0] rpl_st = cmd_known ? `USIO_ST_ACK : `USIO_ST_NACK;
  wire [7:0] out_byte = rpl_reg[idx_reg];
  // only the parameters are scrambled, so a host can always frame the reply
  wire [7:0] out_enc = (data_enc && idx_reg >= `USIO_RPL_HEAD) ? out_byte ^ `USIO_CRYPT_KEY
                                                                : out_byte;
  wire tx_free = !tx_busy && !tx_vld_reg;
  wire init_done = (init_cnt_reg >= `USIO_INIT_CYC);

  usio_uart u_uart (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .div(div_reg),
    .tx_valid(tx_vld_reg),
    .tx_data(tx_dat_reg),
    .tx_busy(tx_busy),
    .tx_line(lnk.d2h),
    .rx_line(lnk.h2d),
    .rx_valid(rx_valid),
    .rx_data(rx_data)
  );

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= DS_INIT;
      post_reg <= PO_NONE;
      cmd_reg <= 8'h00;
      arg_reg <= 32'h0;
      idx_reg <= 3'd0;
      len_reg <= 3'd0;
      for (int i = 0; i < 7; i++) rpl_reg[i] <= 8'h00;
      div_reg <= `USIO_DIV_RST;
      div_new_reg <= `USIO_DIV_RST;
      baud_new_reg <= `USIO_BAUD_RST;
      baud_rate <= `USIO_BAUD_RST;
      data_enc <= 1'b0;
      hdr_b <= 1'b0;
      asleep <= 1'b0;
      nv_write <= 1'b0;
      init_cnt_reg <= 32'h0;
      tx_vld_reg <= 1'b0;
      tx_dat_reg <= 8'h00;
      gpio_out <= '0;
      gpio_oe_n <= '1;
      gpio_ie <= '0;
    end else begin
      tx_vld_reg <= 1'b0;
      nv_write <= 1'b0;
      unique case (state_reg)
        DS_INIT: begin
          // link settings are kept, pins come back released
          init_cnt_reg <= init_cnt_reg + 32'h1;
          gpio_out <= '0;
          gpio_oe_n <= '1;
          gpio_ie <= '0;
          if (init_done) begin
            rpl_reg[0] <= rpl_hdr;
            rpl_reg[1] <= `USIO_ST_START;
            rpl_reg[2] <= 8'h00;
            len_reg <= `USIO_RPL_HEAD;
            idx_reg <= 3'd0;
            post_reg <= PO_NONE;
            state_reg <= DS_SEND;
          end
        end
        DS_CMD: begin
          if (rx_valid) begin
            cmd_reg <= rx_data;
            arg_reg <= 32'h0;
            idx_reg <= 3'd0;
            state_reg <= (n_args == 3'd0) ? DS_EXEC : DS_ARG;
          end
        end
        DS_ARG: begin
          if (rx_valid) begin
            arg_reg[{idx_reg[1:0], 3'b000} +: 8] <= rx_data;
            idx_reg <= idx_reg + 3'd1;
            if (idx_reg == usio_arg_count(cmd_reg) - 3'd1) state_reg <= DS_EXEC;
          end
        end
        DS_EXEC: begin
          rpl_reg[0] <= rpl_hdr;
          rpl_reg[1] <= rpl_st;
          rpl_reg[2] <= {5'h0, rpl_np};
          rpl_reg[3] <= rpl_par[7:0];
          rpl_reg[4] <= rpl_par[15:8];
          rpl_reg[5] <= rpl_par[23:16];
          rpl_reg[6] <= rpl_par[31:24];
          len_reg <= `USIO_RPL_HEAD + rpl_np;
          idx_reg <= 3'd0;
          post_reg <= PO_NONE;
          if (cmd_reg == `USIO_CMD_SLEEP) post_reg <= PO_SLEEP;
          if (cmd_reg == `USIO_CMD_RESET) post_reg <= PO_RESET;
          if (is_baud) begin
            div_new_reg <= req_div;
            baud_new_reg <= got_rate;
            post_reg <= PO_BAUD;
          end
          if (cmd_reg == `USIO_CMD_DTYPE && cfg_ok) post_reg <= PO_DTYPE;
          if (cmd_reg == `USIO_CMD_HTYPE && cfg_ok) post_reg <= PO_HTYPE;
          // pin is set up before its ack leaves
          if (cmd_reg == `USIO_CMD_SETPIN && pin_ok && mode_ok) begin
            gpio_oe_n[pin_sel] <= (pin_arg[1:0] < `USIO_PIN_LOW);
            gpio_out[pin_sel] <= (pin_arg[1:0] == `USIO_PIN_HIGH);
            gpio_ie[pin_sel] <= (pin_arg[1:0] == `USIO_PIN_IN);
          end
          state_reg <= DS_SEND;
        end
        DS_SEND: begin
          if (tx_free && idx_reg != len_reg) begin
            tx_vld_reg <= 1'b1;
            tx_dat_reg <= out_enc;
            idx_reg <= idx_reg + 3'd1;
          end else if (tx_free) begin
            // last stop bit is out: new settings apply from here
            state_reg <= DS_CMD;
            unique case (post_reg)
              PO_NONE: begin
              end
              PO_SLEEP: begin
                asleep <= 1'b1;
                state_reg <= DS_SLEEP;
              end
              PO_RESET: begin
                init_cnt_reg <= 32'h0;
                state_reg <= DS_INIT;
              end
              PO_BAUD: begin
                div_reg <= div_new_reg;
                baud_rate <= baud_new_reg;
                nv_write <= 1'b1;
              end
              PO_DTYPE: begin
                data_enc <= arg_reg[0];
                nv_write <= 1'b1;
              end
              PO_HTYPE: begin
                hdr_b <= arg_reg[0];
                nv_write <= 1'b1;
              end
            endcase
          end
        end
        DS_SLEEP: begin
          // anything but the wake byte is dropped while asleep
          if (rx_valid && rx_data == `USIO_WAKE_BYTE) begin
            asleep <= 1'b0;
            cmd_reg <= `USIO_CMD_DUMMY;
            state_reg <= DS_EXEC;
          end
        end
      endcase
    end
  end
endmodule // usio_dev

// ---- rtl/usio_host.sv ----
// host end: frames commands, collects replies, paces configuration changes
`timescale 1ns/100ps
`include "usio_cfg.svh"
module usio_host
  import usio_pkg::*;
#(
  parameter logic [31:0] HOLD_CYC = `USIO_HOLD_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // link
  usio_if.host lnk,
  // command request
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [31:0] cmd_arg,
  output logic cmd_ready,
  // reply
  output logic rsp_valid,
  output logic [7:0] rsp_status,
  output logic [2:0] rsp_len,
  output logic [31:0] rsp_data,
  output logic rsp_hdr_b
);
  import usio_pkg::*;

  usio_hstate_t state_reg;
  logic [7:0] code_reg;
  logic [31:0] arg_reg;
  logic [2:0] idx_reg;
  logic [1:0] need_reg;
  logic [15:0] div_reg;
  logic enc_reg;
  logic [31:0] hold_reg;
  logic tx_vld_reg;
  logic [7:0] tx_dat_reg;
  logic tx_busy;
  logic rx_valid;
  logic [7:0] rx_data;

  wire [2:0] n_args = usio_arg_count(code_reg);
  wire tx_free = !tx_busy && !tx_vld_reg;
  wire [7:0] tx_pick = (idx_reg == 3'd0) ? code_reg : arg_reg[{idx_reg[1:0] - 2'd1, 3'b000} +: 8];
  wire [7:0] rx_plain = enc_reg ? rx_data ^ `USIO_CRYPT_KEY : rx_data;
  wire rx_last = (idx_reg == 3'd2 && rx_data == 8'h00) ||
                 (idx_reg > 3'd2 && idx_reg == rsp_len + 3'd2);
  wire acked = (rsp_status == `USIO_ST_ACK);
  wire cfg_cmd = (code_reg == `USIO_CMD_BAUD) ||
                 (code_reg == `USIO_CMD_DTYPE) || (code_reg == `USIO_CMD_HTYPE);

  usio_uart u_uart (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .div(div_reg),
    .tx_valid(tx_vld_reg),
    .tx_data(tx_dat_reg),
    .tx_busy(tx_busy),
    .tx_line(lnk.h2d),
    .rx_line(lnk.d2h),
    .rx_valid(rx_valid),
    .rx_data(rx_data)
  );

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= HS_IDLE;
      code_reg <= 8'h00;
      arg_reg <= 32'h0;
      idx_reg <= 3'd0;
      need_reg <= 2'd0;
      div_reg <= `USIO_DIV_RST;
      enc_reg <= 1'b0;
      hold_reg <= 32'h0;
      tx_vld_reg <= 1'b0;
      tx_dat_reg <= 8'h00;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_status <= 8'h00;
      rsp_len <= 3'd0;
      rsp_data <= 32'h0;
      rsp_hdr_b <= 1'b0;
    end else begin
      tx_vld_reg <= 1'b0;
      rsp_valid <= 1'b0;
      unique case (state_reg)
        HS_IDLE: begin
          // settle time after a configuration ack
          if (hold_reg != 32'h0) hold_reg <= hold_reg - 32'h1;
          cmd_ready <= (hold_reg <= 32'h1);
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            code_reg <= cmd_code;
            arg_reg <= cmd_arg;
            idx_reg <= 3'd0;
            state_reg <= HS_SEND;
          end
        end
        HS_SEND: begin
          if (tx_free && idx_reg != n_args + 3'd1) begin
            tx_vld_reg <= 1'b1;
            tx_dat_reg <= tx_pick;
            idx_reg <= idx_reg + 3'd1;
          end else if (tx_free) begin
            // reset brings an ack and then the start notice
            need_reg <= (code_reg == `USIO_CMD_RESET) ? 2'd2 : 2'd1;
            idx_reg <= 3'd0;
            state_reg <= HS_RX;
          end
        end
        HS_RX: begin
          if (rx_valid) begin
            idx_reg <= idx_reg + 3'd1;
            if (idx_reg == 3'd0) begin
              rsp_hdr_b <= (rx_data == `USIO_HDR_B);
              rsp_data <= 32'h0;
            end
            if (idx_reg == 3'd1) rsp_status <= rx_data;
            if (idx_reg == 3'd2) rsp_len <= rx_data[2:0];
            if (idx_reg > 3'd2) rsp_data[{idx_reg[1:0] - 2'd3, 3'b000} +: 8] <= rx_plain;
            if (rx_last) begin
              rsp_valid <= 1'b1;
              need_reg <= need_reg - 2'd1;
              state_reg <= HS_POST;
            end
          end
        end
        HS_POST: begin
          idx_reg <= 3'd0;
          state_reg <= (need_reg != 2'd0) ? HS_RX : HS_IDLE;
          if (acked && code_reg == `USIO_CMD_BAUD) div_reg <= usio_div_of(rsp_data);
          if (acked && code_reg == `USIO_CMD_DTYPE && arg_reg[7:0] <= `USIO_CFG_MAX)
            enc_reg <= arg_reg[0];
          if (acked && cfg_cmd) hold_reg <= HOLD_CYC;
        end
      endcase
    end
  end
endmodule // usio_host

// ---- dv/usio_link_checker.sv ----
// serial link checks between the host and device ends
`timescale 1ns/100ps
`include "usio_cfg.svh"
module usio_link_checker (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // link lines
  input wire logic h2d,
  input wire logic d2h
);
  logic h2d_q;
  logic d2h_q;
  logic [15:0] h2d_run;
  logic [15:0] d2h_run;
  wire logic h2d_edge = (h2d != h2d_q);
  wire logic d2h_edge = (d2h != d2h_q);
  // run lengths saturate so a long idle never wraps into a short bit
  wire logic [15:0] h2d_run_next = h2d_edge ? 16'h1 : h2d_run + 16'(h2d_run != 16'hffff);
  wire logic [15:0] d2h_run_next = d2h_edge ? 16'h1 : d2h_run + 16'(d2h_run != 16'hffff);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      h2d_q <= 1'b1;
      d2h_q <= 1'b1;
      h2d_run <= 16'h0;
      d2h_run <= 16'h0;
    end else begin
      h2d_q <= h2d;
      d2h_q <= d2h;
      h2d_run <= h2d_run_next;
      d2h_run <= d2h_run_next;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  h2d_bit_len_a: assert property (h2d_edge |-> h2d_run >= 16'(`USIO_DIV_MIN))
    else $error("host line bit shorter than the minimum divider");
  d2h_bit_len_a: assert property (d2h_edge |-> d2h_run >= 16'(`USIO_DIV_MIN))
    else $error("device line bit shorter than the minimum divider");
  link_half_duplex_a: assert property (!(h2d == 1'b0 && d2h == 1'b0))
    else $error("device talked while the host was sending");
  init_quiet_a: assert property ($rose(rst_n) |-> d2h [*8])
    else $error("device line active during initialisation");
  // a reply may only start once the host line has sat in its stop bit a while
  reply_after_stop_a: assert property ($fell(d2h) |-> h2d && h2d_run >= 16'h8)
    else $error("device reply began before the host stop bit");
  host_quiet_init_a: assert property ($rose(rst_n) |-> h2d [*8])
    else $error("host line active right after reset");

  cover property (d2h_edge && d2h_run == 16'(`USIO_DIV_MIN));
endmodule // usio_link_checker

// ---- dv/tb_top.sv ----
// self-checking bench: host and device ends joined over the link
`timescale 1ns/100ps
`include "usio_cfg.svh"
module tb_top;
  import usio_pkg::*;
  localparam logic [31:0] HOLD = 32'd200;
  localparam logic [31:0] FAST = `USIO_CLK_HZ / `USIO_DIV_MIN;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic [7:0] cmd_code = 8'h00;
  logic [31:0] cmd_arg = 32'h0;
  logic [7:0] gpio_in = 8'h00;
  logic [7:0] gpio_out, gpio_oe_n, gpio_ie;
  logic asleep, data_enc, hdr_b, nv_write, cmd_ready, rsp_valid, rsp_hdr_b;
  logic [31:0] baud_rate, rsp_data, dt;
  logic [7:0] rsp_status, st, st1;
  logic [2:0] rsp_len, ln;
  logic hb;
  int n_fail = 0;
  int checks = 0;
  int bitlen = 0;
  int nv_cnt = 0;

  usio_if usio_if_inst ();
  usio_dev usio_dev_inst (.sys_clk(sys_clk), .rst_n(rst_n), .lnk(usio_if_inst.dev),
    .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .gpio_ie(gpio_ie),
    .asleep(asleep), .data_enc(data_enc), .hdr_b(hdr_b), .baud_rate(baud_rate),
    .nv_write(nv_write));
  usio_host #(.HOLD_CYC(HOLD)) usio_host_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .lnk(usio_if_inst.host), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_arg(cmd_arg),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_status(rsp_status),
    .rsp_len(rsp_len), .rsp_data(rsp_data), .rsp_hdr_b(rsp_hdr_b));
  usio_link_checker usio_link_checker_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .h2d(usio_if_inst.h2d), .d2h(usio_if_inst.d2h));

  always #2.5 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    if (nv_write === 1'b1) begin
      nv_cnt++;
    end
  end

  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // one command through the host, keeping the status of the first reply and all of the last
  task automatic run_cmd(input logic [7:0] code, input logic [31:0] arg, input int nrsp);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 20000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (cmd_ready !== 1'b1) begin
      check_val("ready wait", 32'h1, {31'h0, cmd_ready});
      stop_test();
    end
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_code <= code;
    cmd_arg <= arg;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    for (int k = 0; k < nrsp; k++) begin
      n = 0;
      do begin
        @(posedge sys_clk);
        #1;
        n++;
      end while (rsp_valid !== 1'b1 && n < 20000);
      if (rsp_valid !== 1'b1) begin
        check_val("reply wait", 32'h1, {31'h0, rsp_valid});
        stop_test();
      end
      if (k == 0) begin
        st1 = rsp_status;
      end
    end
    st = rsp_status;
    ln = rsp_len;
    dt = rsp_data;
    hb = rsp_hdr_b;
    // the device adopts new settings only after its last stop bit ends
    repeat (`USIO_DIV_RST) @(posedge sys_clk);
    #1;
  endtask

  // start bit of a 0xa5 header is a lone low bit: its length is the divider
  task automatic measure();
    @(negedge usio_if_inst.d2h);
    bitlen = 0;
    do begin
      @(posedge sys_clk);
      bitlen++;
      #1;
    end while (usio_if_inst.d2h === 1'b0 && bitlen < 4000);
  endtask

  initial begin
    // about twice the expected length of all tests
    repeat (80000) @(posedge sys_clk);
    $display("unexpected run time: expected done, seen still running");
    n_fail++;
    stop_test();
  end

  initial begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    // init plus a three byte start packet at the reset rate
    repeat (`USIO_INIT_CYC + 30 * `USIO_DIV_RST + 200) @(posedge sys_clk);
    check_val("reset rate", `USIO_BAUD_RST, baud_rate);
    // too fast a request clamps to the smallest divider
    fork
      measure();
      run_cmd(`USIO_CMD_BAUD, 32'd20000000, 1);
    join
    check_val("baud ack status", `USIO_ST_ACK, st);
    check_val("baud ack len", 3'd4, ln);
    check_val("achieved rate", FAST, dt);
    check_val("old rate bit", `USIO_DIV_RST, bitlen);
    check_val("rate in use", FAST, baud_rate);
    $display("test baud done");
    fork
      measure();
      run_cmd(`USIO_CMD_DUMMY, 32'h0, 1);
    join
    check_val("dummy status", `USIO_ST_ACK, st);
    check_val("dummy len", 3'd0, ln);
    check_val("new rate bit", `USIO_DIV_MIN, bitlen);
    $display("test dummy done");
    run_cmd(`USIO_CMD_DTYPE, 32'h1, 1);
    check_val("settle hold", 1'b0, cmd_ready);
    check_val("dtype ack len", 3'd0, ln);
    check_val("encrypted", 1'b1, data_enc);
    run_cmd(`USIO_CMD_DTYPE, 32'h2, 1);
    check_val("bad dtype kept", 1'b1, data_enc);
    run_cmd(`USIO_CMD_HTYPE, 32'h1, 1);
    check_val("htype ack old header", 1'b0, hb);
    check_val("second header", 1'b1, hdr_b);
    run_cmd(`USIO_CMD_HTYPE, 32'h0, 1);
    check_val("htype ack old header", 1'b1, hb);
    check_val("first header", 1'b0, hdr_b);
    check_val("persist strobes", 4, nv_cnt);
    $display("test config done");
    for (int m = 0; m < 4; m++) begin
      run_cmd(`USIO_CMD_SETPIN, {16'h0, 8'(m), 8'h07}, 1);
      check_val("set ack len", 3'd0, ln);
      check_val("pin drive enable", (m >= 2) ? 1'b0 : 1'b1, gpio_oe_n[7]);
      check_val("pin level", (m == 3), gpio_out[7]);
      check_val("pin input", (m == 1), gpio_ie[7]);
    end
    run_cmd(`USIO_CMD_SETPIN, {16'h0, 8'h01, 8'h08}, 1);
    run_cmd(`USIO_CMD_SETPIN, {16'h0, 8'h04, 8'h07}, 1);
    check_val("pins kept enables", 8'h7f, gpio_oe_n);
    check_val("pins kept inputs", 8'h00, gpio_ie);
    run_cmd(`USIO_CMD_SETPIN, {16'h0, 8'h01, 8'h00}, 1);
    @(posedge sys_clk);
    gpio_in <= 8'h01;
    run_cmd(`USIO_CMD_GETPIN, 32'h0, 1);
    check_val("read len", 3'd1, ln);
    check_val("read high", 32'h1, dt);
    @(posedge sys_clk);
    gpio_in <= 8'hfe;
    run_cmd(`USIO_CMD_GETPIN, 32'h0, 1);
    check_val("read low", 32'h0, dt);
    $display("test pins done");
    run_cmd(8'h01, 32'h0, 1);
    check_val("unknown code status", `USIO_ST_NACK, st);
    run_cmd(`USIO_CMD_SLEEP, 32'h0, 1);
    check_val("sleep ack", `USIO_ST_ACK, st);
    check_val("asleep", 1'b1, asleep);
    run_cmd(`USIO_WAKE_BYTE, 32'h0, 1);
    check_val("wake ack", `USIO_ST_ACK, st);
    check_val("awake", 1'b0, asleep);
    $display("test sleep done");
    run_cmd(`USIO_CMD_RESET, 32'h0, 2);
    check_val("reset ack", `USIO_ST_ACK, st1);
    check_val("start packet", `USIO_ST_START, st);
    check_val("pins released", 8'hff, gpio_oe_n);
    check_val("rate kept", FAST, baud_rate);
    check_val("type kept", 1'b1, data_enc);
    $display("test reset done");
    stop_test();
  end
endmodule // tb_top
